/* logic/pgf_dividers.sv */
// module: three filter sample enable dividers
`timescale 1ns/1ps
module pgf_dividers (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // division codes
    input  wire logic [1:0] div1_code,
    input  wire logic [2:0] div2_code,
    input  wire logic [2:0] div3_code,
    // oscillator pin, asynchronous
    input  wire logic       low_power_osc_clock,
    // tick outputs
    pgf_tick_if.src         ticks
);
    typedef struct packed {
        logic [2:0]                    lpo_sync; // three stage synchroniser
        logic [pgf_pkg::BUS_CNT_W-1:0] bus_cnt;  // free running bus count
        logic [pgf_pkg::LPO_CNT_W-1:0] lpo_cnt;  // oscillator edge count
        logic                          lpo_lvl;  // agreed oscillator level
        logic                          t1;
        logic                          t2;
        logic                          t3;
    } pgf_div_state_type;

    pgf_div_state_type st;      // registered state
    pgf_div_state_type next_st; // next state

    // tick generation from the counters
    always_comb begin
        logic [pgf_pkg::BUS_CNT_W-1:0] m1;
        logic [pgf_pkg::BUS_CNT_W-1:0] m2;
        logic [pgf_pkg::LPO_CNT_W:0]   m3;
        logic                          rise;
        next_st = st;
        // stage one is read only by stage two
        next_st.lpo_sync = {st.lpo_sync[1:0], low_power_osc_clock};
        next_st.bus_cnt  = st.bus_cnt + 1'b1;
        // edge counts once stages two and three agree on the new level
        next_st.lpo_lvl  = (st.lpo_sync[1] == st.lpo_sync[2]) ? st.lpo_sync[2] : st.lpo_lvl;
        rise = st.lpo_sync[1] & st.lpo_sync[2] & ~st.lpo_lvl;
        m1 = (pgf_pkg::BUS_CNT_W'(1) << (div1_code + pgf_pkg::DIV1_BASE_LOG2)) - 1'b1;
        m2 = (pgf_pkg::BUS_CNT_W'(1) << (div2_code + pgf_pkg::DIV2_BASE_LOG2)) - 1'b1;
        // oscillator divide by 1 to 128
        m3 = ((pgf_pkg::LPO_CNT_W+1)'(1) << div3_code) - 1'b1;
        next_st.t1 = (st.bus_cnt & m1) == m1;
        next_st.t2 = (st.bus_cnt & m2) == m2;
        next_st.t3 = rise && ((st.lpo_cnt & m3[pgf_pkg::LPO_CNT_W-1:0])
                              == m3[pgf_pkg::LPO_CNT_W-1:0]);
        if (rise) begin
            next_st.lpo_cnt = st.lpo_cnt + 1'b1;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ticks.divided_clock_one   = st.t1;
    assign ticks.divided_clock_two   = st.t2;
    assign ticks.divided_clock_three = st.t3;
endmodule

/* logic/pgf_glitch_cell.sv */
// module: one input pin synchroniser and glitch filter
`timescale 1ns/1ps
module pgf_glitch_cell (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // sample enables
    pgf_tick_if.dst         ticks,
    // control
    input  wire logic [1:0] sel,
    input  wire logic       gate,
    // pin and result
    input  wire logic       raw,
    output logic            filt
);
    typedef struct packed {
        logic [2:0] sync; // three stage synchroniser
        logic       held; // last agreed pin level
        logic [1:0] cnt;  // consecutive differing samples
        logic       out;  // filtered level
    } pgf_cell_state_type;

    pgf_cell_state_type st;      // registered state
    pgf_cell_state_type next_st; // next state

    // sample on the chosen tick, move after enough agreeing samples
    always_comb begin
        logic tick;
        logic smp;
        next_st      = st;
        tick         = 1'b0;
        next_st.sync = {st.sync[1:0], raw};
        // accept a change only when stages two and three agree
        smp          = (st.sync[1] == st.sync[2]) ? st.sync[2] : st.held;
        next_st.held = smp;
        case (pgf_pkg::pgf_sel_type'(sel))
            pgf_pkg::SEL_BUS_CLOCK: tick = 1'b1;
            pgf_pkg::SEL_DIV_ONE:   tick = ticks.divided_clock_one;
            pgf_pkg::SEL_DIV_TWO:   tick = ticks.divided_clock_two;
            pgf_pkg::SEL_DIV_THREE: tick = ticks.divided_clock_three;
            default:                tick = 1'b0;
        endcase
        if (!gate) begin
            // disabled input reads low and forgets history
            next_st.out = 1'b0;
            next_st.cnt = 2'h0;
        end else if (tick) begin
            if (smp == st.out) begin
                next_st.cnt = 2'h0;
            end else if (st.cnt + 1'b1 >= pgf_pkg::STABLE_SAMPLES) begin
                next_st.out = smp;
                next_st.cnt = 2'h0;
            end else begin
                next_st.cnt = st.cnt + 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign filt = st.out;
endmodule

/* logic/pgf_pkg.sv */
// package: register map, field layout and timing constants of the port glitch filter
package pgf_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_PORT_C_INPUT_GATE   = 16'h30BA;
    localparam logic [15:0] IDX_PORT_GROUP_FILTER   = 16'h30EC;
    localparam logic [15:0] IDX_WAKEUP_RESET_FILTER = 16'h30EE;
    localparam logic [15:0] IDX_FILTER_CLOCK_DIV    = 16'h30EF;
    localparam int          ADDR_W                  = 16;
    localparam logic [ADDR_W-1:0] ADDR_PORT_C_INPUT_GATE   = ADDR_W'(IDX_PORT_C_INPUT_GATE * 4);
    localparam logic [ADDR_W-1:0] ADDR_PORT_GROUP_FILTER   = ADDR_W'(IDX_PORT_GROUP_FILTER * 4);
    localparam logic [ADDR_W-1:0] ADDR_WAKEUP_RESET_FILTER = ADDR_W'(IDX_WAKEUP_RESET_FILTER * 4);
    localparam logic [ADDR_W-1:0] ADDR_FILTER_CLOCK_DIV    = ADDR_W'(IDX_FILTER_CLOCK_DIV * 4);

    // field positions
    localparam int PORT_C_GATE_W  = 4;
    localparam int FLT_A_LSB      = 0;
    localparam int FLT_B_LSB      = 2;
    localparam int FLT_C_LSB      = 4;
    localparam int FLT_RST_LSB    = 0;
    localparam int FLT_KBI_LSB    = 2;
    localparam int FLT0_W         = 6;
    localparam int FLT2_W         = 4;
    localparam int DIV1_LSB       = 0;
    localparam int DIV1_W         = 2;
    localparam int DIV2_LSB       = 2;
    localparam int DIV2_W         = 3;
    localparam int DIV3_LSB       = 5;
    localparam int DIV3_W         = 3;

    // reset values
    localparam logic [3:0] RST_PORT_C_GATE = 4'h0;
    localparam logic [5:0] RST_FLT0        = 6'h00;
    localparam logic [3:0] RST_FLT2        = 4'h0;
    localparam logic [7:0] RST_FCLKDIV     = 8'h00;

    // divider bases: log2 of the division at code zero
    localparam int DIV1_BASE_LOG2 = 1;
    localparam int DIV2_BASE_LOG2 = 5;
    localparam int BUS_CNT_W      = 12;
    localparam int LPO_CNT_W      = 7;

    // consecutive equal samples needed before the output moves
    localparam logic [1:0] STABLE_SAMPLES = 2'h2;

    // filter clock choice codes
    typedef enum logic [1:0] {
        SEL_BUS_CLOCK = 2'h0,
        SEL_DIV_ONE   = 2'h1,
        SEL_DIV_TWO   = 2'h2,
        SEL_DIV_THREE = 2'h3
    } pgf_sel_type;
endpackage

/* logic/pgf_port_filter.sv */
// module: port input glitch filter top with apb register slave
//
// Operation
// - port c input gate bits enable pins
// - reserved bits read zero, ignore writes
// - port c filter clock select field
// - port b filter clock select field
// - port a filter clock select field
// - keyboard inputs filter clock select field
// - reset irq pin filter clock select
// - stop mode forces divided clock three on keyboard and reset pin when divider one or two is chosen
// - pulses under one period are discarded
// - levels over two periods pass through
// - divider three: oscillator over two power code
// - divider two: bus over 32 to 4096
// - divider one: bus over 2 to 16
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module pgf_port_filter #(
    parameter int PA_W  = 8, // port a pins
    parameter int PB_W  = 8, // port b pins
    parameter int PC_W  = 4, // port c pins
    parameter int KBI_W = 8  // keyboard interrupt inputs
) (
    // clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [pgf_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // power mode, from logic on the bus clock
    input  wire logic                      stop_mode,
    // oscillator pin
    input  wire logic                      low_power_osc_clock,
    // raw pins
    input  wire logic [PA_W-1:0]           port_a,
    input  wire logic [PB_W-1:0]           port_b,
    input  wire logic [PC_W-1:0]           port_c,
    input  wire logic [KBI_W-1:0]          keyboard_interrupt_inputs,
    input  wire logic                      reset_irq_pin,
    // filtered inputs to internal logic
    output logic      [PA_W-1:0]           port_a_filtered,
    output logic      [PB_W-1:0]           port_b_filtered,
    output logic      [PC_W-1:0]           port_c_filtered,
    output logic      [KBI_W-1:0]          keyboard_filtered,
    output logic                           reset_irq_filtered
);
    // all filtered inputs in one vector
    localparam int TOT = PA_W + PB_W + PC_W + KBI_W + 1;
    localparam int OFS_B = PA_W;
    localparam int OFS_C = PA_W + PB_W;
    localparam int OFS_K = PA_W + PB_W + PC_W;
    localparam int OFS_R = TOT - 1;

    typedef struct packed {
        logic [pgf_pkg::PORT_C_GATE_W-1:0] port_c_input_gate;
        logic [pgf_pkg::FLT0_W-1:0]        port_group_filter_select;
        logic [pgf_pkg::FLT2_W-1:0]        wakeup_reset_filter_select;
        logic [7:0]                        filter_clock_dividers;
        logic [31:0]                       rdata;  // read data, loaded in setup
        logic                              err;    // unmapped address flag
    } pgf_top_state_type;

    pgf_top_state_type st;      // registered state
    pgf_top_state_type next_st; // next state

    // decoded selection fields
    logic [1:0] port_a_filter_select;
    logic [1:0] port_b_filter_select;
    logic [1:0] port_c_filter_select;
    logic [1:0] keyboard_irq_filter_select;
    logic [1:0] reset_irq_pin_filter_select;
    logic [1:0] kbi_sel_eff;   // keyboard choice after stop override
    logic [1:0] rst_sel_eff;   // reset pin choice after stop override
    // per pin vectors
    logic [TOT-1:0] raw_all;   // every raw pin
    logic [TOT-1:0] filt_all;  // every filtered result
    logic [TOT-1:0] gate_all;  // input gate per pin
    logic [1:0]     sel_all [TOT];

    // address hits
    logic hit_gate;
    logic hit_flt0;
    logic hit_flt2;
    logic hit_div;
    logic hit_any;
    logic setup_ph;            // setup cycle of an apb transfer
    logic wr_access;           // write taken this edge
    logic lane0;               // low byte lane written

    pgf_tick_if ticks ();      // shared sample enables

    // field extraction
    // port a field
    assign port_a_filter_select = st.port_group_filter_select[pgf_pkg::FLT_A_LSB +: 2];
    assign port_b_filter_select = st.port_group_filter_select[pgf_pkg::FLT_B_LSB +: 2];
    assign port_c_filter_select = st.port_group_filter_select[pgf_pkg::FLT_C_LSB +: 2];
    assign keyboard_irq_filter_select =
        st.wakeup_reset_filter_select[pgf_pkg::FLT_KBI_LSB +: 2];
    assign reset_irq_pin_filter_select =
        st.wakeup_reset_filter_select[pgf_pkg::FLT_RST_LSB +: 2];

    // stop override, purely combinational so release is immediate
    always_comb begin
        kbi_sel_eff = keyboard_irq_filter_select;
        rst_sel_eff = reset_irq_pin_filter_select;
        if (stop_mode && (keyboard_irq_filter_select == pgf_pkg::SEL_DIV_ONE ||
                          keyboard_irq_filter_select == pgf_pkg::SEL_DIV_TWO)) begin
            kbi_sel_eff = pgf_pkg::SEL_DIV_THREE;
        end
        if (stop_mode && (reset_irq_pin_filter_select == pgf_pkg::SEL_DIV_ONE ||
                          reset_irq_pin_filter_select == pgf_pkg::SEL_DIV_TWO)) begin
            rst_sel_eff = pgf_pkg::SEL_DIV_THREE;
        end
    end

    // apb decode
    assign hit_gate  = (paddr == pgf_pkg::ADDR_PORT_C_INPUT_GATE);
    assign hit_flt0  = (paddr == pgf_pkg::ADDR_PORT_GROUP_FILTER);
    assign hit_flt2  = (paddr == pgf_pkg::ADDR_WAKEUP_RESET_FILTER);
    assign hit_div   = (paddr == pgf_pkg::ADDR_FILTER_CLOCK_DIV);
    assign hit_any   = hit_gate | hit_flt0 | hit_flt2 | hit_div;
    assign setup_ph  = psel & ~penable;
    // no wait states: answer in the access cycle right after setup
    assign pready    = psel & penable;
    assign wr_access = psel & penable & pwrite & ~st.err;
    assign lane0     = pstrb[0];
    assign prdata    = st.rdata;
    assign pslverr   = psel & penable & st.err;

    // register file and read capture
    always_comb begin
        next_st = st;
        if (setup_ph) begin
            // error and read data fixed a cycle early so they leave a flop
            next_st.err   = ~hit_any;
            next_st.rdata = 32'h0000_0000;
            if (!pwrite) begin
                case (1'b1)
                    hit_gate: next_st.rdata[pgf_pkg::PORT_C_GATE_W-1:0] = st.port_c_input_gate;
                    hit_flt0: next_st.rdata[pgf_pkg::FLT0_W-1:0] = st.port_group_filter_select;
                    hit_flt2: next_st.rdata[pgf_pkg::FLT2_W-1:0] = st.wakeup_reset_filter_select;
                    hit_div:  next_st.rdata[7:0] = st.filter_clock_dividers;
                    default:  next_st.rdata = 32'h0000_0000;
                endcase
            end
        end
        if (wr_access && lane0) begin
            if (hit_gate) begin
                next_st.port_c_input_gate = pwdata[pgf_pkg::PORT_C_GATE_W-1:0];
            end
            if (hit_flt0) begin
                next_st.port_group_filter_select = pwdata[pgf_pkg::FLT0_W-1:0];
            end
            if (hit_flt2) begin
                next_st.wakeup_reset_filter_select = pwdata[pgf_pkg::FLT2_W-1:0];
            end
            if (hit_div) begin
                next_st.filter_clock_dividers = pwdata[7:0];
            end
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.port_c_input_gate          <= pgf_pkg::RST_PORT_C_GATE;
            st.port_group_filter_select   <= pgf_pkg::RST_FLT0;
            st.wakeup_reset_filter_select <= pgf_pkg::RST_FLT2;
            st.filter_clock_dividers      <= pgf_pkg::RST_FCLKDIV;
            st.rdata                      <= 32'h0000_0000;
            st.err                        <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // divider chain shared by all cells
    pgf_dividers u_div (
        .pclk                (pclk),
        .presetn             (presetn),
        .div1_code           (st.filter_clock_dividers[pgf_pkg::DIV1_LSB +: pgf_pkg::DIV1_W]),
        .div2_code           (st.filter_clock_dividers[pgf_pkg::DIV2_LSB +: pgf_pkg::DIV2_W]),
        .div3_code           (st.filter_clock_dividers[pgf_pkg::DIV3_LSB +: pgf_pkg::DIV3_W]),
        .low_power_osc_clock (low_power_osc_clock),
        .ticks               (ticks)
    );

    // gather pins in one order: a, b, c, keyboard, reset
    assign raw_all = {reset_irq_pin, keyboard_interrupt_inputs, port_c, port_b, port_a};

    // one filter cell per pin
    genvar i;
    generate
        for (i = 0; i < TOT; i++) begin : g_cell
            if (i < OFS_B) begin : g_a
                assign sel_all[i]  = port_a_filter_select;
                assign gate_all[i] = 1'b1;
            end else if (i < OFS_C) begin : g_b
                assign sel_all[i]  = port_b_filter_select;
                assign gate_all[i] = 1'b1;
            end else if (i < OFS_K) begin : g_c
                assign sel_all[i]  = port_c_filter_select;
                assign gate_all[i] = st.port_c_input_gate[i - OFS_C];
            end else if (i < OFS_R) begin : g_k
                assign sel_all[i]  = kbi_sel_eff;
                assign gate_all[i] = 1'b1;
            end else begin : g_r
                assign sel_all[i]  = rst_sel_eff;
                assign gate_all[i] = 1'b1;
            end
            pgf_glitch_cell u_cell (
                .pclk    (pclk),
                .presetn (presetn),
                .ticks   (ticks),
                .sel     (sel_all[i]),
                .gate    (gate_all[i]),
                .raw     (raw_all[i]),
                .filt    (filt_all[i])
            );
        end
    endgenerate

    // split results back per group
    assign port_a_filtered    = filt_all[OFS_B-1:0];
    assign port_b_filtered    = filt_all[OFS_C-1:OFS_B];
    assign port_c_filtered    = filt_all[OFS_K-1:OFS_C];
    assign keyboard_filtered  = filt_all[OFS_R-1:OFS_K];
    assign reset_irq_filtered = filt_all[OFS_R];
endmodule

/* logic/pgf_tick_if.sv */
// interface: filter sample enables from the divider to every filter cell
`timescale 1ns/1ps
interface pgf_tick_if;
    logic divided_clock_one;   // bus clock based tick, fast
    logic divided_clock_two;   // bus clock based tick, slow
    logic divided_clock_three; // low power oscillator based tick
    modport src (output divided_clock_one, output divided_clock_two, output divided_clock_three);
    modport dst (input divided_clock_one, input divided_clock_two, input divided_clock_three);
endinterface

/* tb/pgf_pin_model.sv */
// model: external pins and free running low power oscillator
`timescale 1ns/1ps
module pgf_pin_model #(
    parameter real LPO_HALF_NS = 112.6 // off the bus grid, so phase drifts
) (
    // oscillator and pin levels
    output logic       lpo_clk,
    output logic [4:0] lvl
);
    initial lpo_clk = 1'b0;
    initial lvl = 5'h00;
    // the oscillator runs free, as the real one does
    always #(LPO_HALF_NS) lpo_clk = ~lpo_clk;
    // pin change, launched just after a bus clock edge
    task automatic drive(input int idx, input logic val);
        lvl[idx] <= val;
    endtask
endmodule

/* tb/pgf_port_filter_bench.sv */
// testbench: registers, filter timing and stop override of the port glitch filter
`timescale 1ns/1ps
module pgf_port_filter_bench;
    localparam logic [15:0] A_GATE = pgf_pkg::ADDR_PORT_C_INPUT_GATE;
    localparam logic [15:0] A_GRP  = pgf_pkg::ADDR_PORT_GROUP_FILTER;
    localparam logic [15:0] A_WAK  = pgf_pkg::ADDR_WAKEUP_RESET_FILTER;
    localparam logic [15:0] A_DIV  = pgf_pkg::ADDR_FILTER_CLOCK_DIV;
    logic        pclk = 1'b0;           // bus clock
    logic        presetn = 1'b0;        // reset, active low
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic        stop_mode = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, lpo_clk, rf;
    logic [4:0]  lvl;                   // a, b, c, keyboard, reset pin
    logic [7:0]  fa, fb, kf;
    logic [3:0]  fc;
    int          failures = 0;
    int          n_compared = 0;
    always #12.5 pclk = ~pclk;
    pgf_pin_model i_pgf_pin_model (.lpo_clk(lpo_clk), .lvl(lvl));
    // every bit of a group follows one model pin
    pgf_port_filter i_pgf_port_filter (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_mode(stop_mode),
        .low_power_osc_clock(lpo_clk), .port_a({8{lvl[0]}}), .port_b({8{lvl[1]}}),
        .port_c({4{lvl[2]}}), .keyboard_interrupt_inputs({8{lvl[3]}}), .reset_irq_pin(lvl[4]),
        .port_a_filtered(fa), .port_b_filtered(fb), .port_c_filtered(fc),
        .keyboard_filtered(kf), .reset_irq_filtered(rf));
    task automatic give_verdict();
        if (failures == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one transfer; entered and left just after a rising edge
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s = 4'hF);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {24'h0, d}, s, r, e);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic eexp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, 4'hF, r, e);
        check(r, exp, "read data");
        check({31'h0, e}, {31'h0, eexp}, "read error");
    endtask
    // filtered group as seen by internal logic
    function automatic logic [7:0] outv(input int i);
        case (i)
            0: return fa;
            1: return fb;
            2: return {4'h0, fc};
            3: return kf;
            default: return {7'h00, rf};
        endcase
    endfunction
    function automatic logic [7:0] full(input int i, input logic v);
        return (i == 2) ? {4'h0, {4{v}}} : (i == 4) ? {7'h00, v} : {8{v}};
    endfunction
    // pulse under one period (a full bus cycle when p is 1) is dropped, a held level passes within about two
    task automatic filt(input int i, input int p, input int slack);
        int n;
        i_pgf_pin_model.drive(i, 1'b1);
        repeat ((p > 1) ? p - 1 : 1) @(posedge pclk);
        i_pgf_pin_model.drive(i, 1'b0);
        repeat (p + slack) begin
            @(negedge pclk);
            check(outv(i), full(i, 1'b0), "glitch passed");
        end
        @(posedge pclk);
        i_pgf_pin_model.drive(i, 1'b1);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (outv(i) !== full(i, 1'b1) && n < 2 * p + slack);
        check(outv(i), full(i, 1'b1), "level held back");
        check({31'h0, n >= p + 3}, 32'h1, "level passed too early");
        @(posedge pclk);
        i_pgf_pin_model.drive(i, 1'b0);
        repeat (2 * p + slack) @(posedge pclk);
        check(outv(i), full(i, 1'b0), "low level held back");
    endtask
    task automatic t_regs();
        rd(A_GATE, 32'h0, 1'b0);
        rd(A_GRP, 32'h0, 1'b0);
        rd(A_WAK, 32'h0, 1'b0);
        rd(A_DIV, 32'h0, 1'b0);
        wr(A_GATE, 8'hFF);
        rd(A_GATE, 32'h0F, 1'b0);
        wr(A_GRP, 8'hFF);
        rd(A_GRP, 32'h3F, 1'b0);
        wr(A_WAK, 8'hFF);
        rd(A_WAK, 32'h0F, 1'b0);
        wr(A_DIV, 8'hFF);
        wr(A_DIV, 8'h00, 4'h0);
        rd(A_DIV, 32'hFF, 1'b0);
        wr(16'h0004, 8'h55);
        rd(16'h0004, 32'h0, 1'b1);
        wr(A_GRP, 8'h00);
        wr(A_WAK, 8'h00);
        wr(A_DIV, 8'h00);
        wr(A_GATE, 8'h05);
        i_pgf_pin_model.drive(2, 1'b1);
        repeat (10) @(posedge pclk);
        check({28'h0, fc}, 32'h5, "gate mask");
        i_pgf_pin_model.drive(2, 1'b0);
        wr(A_GATE, 8'h0F);
    endtask
    task automatic t_bus();
        for (int i = 0; i < 5; i++) begin
            filt(i, 1, 8);
        end
    endtask
    task automatic t_dividers();
        wr(A_GRP, 8'h24);
        for (int c = 0; c < 4; c++) begin
            wr(A_DIV, 8'(c));
            filt(1, 2 << c, 8);
        end
        for (int c = 0; c < 8; c++) begin
            wr(A_DIV, 8'(c << 2));
            filt(2, 32 << c, 8);
        end
        wr(A_GRP, 8'h03);
        for (int c = 0; c < 8; c++) begin
            wr(A_DIV, 8'(c << 5));
            filt(0, 9 << c, 16);
        end
    endtask
    task automatic t_stop();
        wr(A_WAK, 8'h06);
        wr(A_DIV, 8'h60);
        stop_mode <= 1'b1;
        filt(3, 72, 20);
        filt(4, 72, 20);
        stop_mode <= 1'b0;
        filt(3, 2, 8);
        filt(4, 32, 8);
    endtask
    initial begin
        repeat (100000) @(posedge pclk);
        failures++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_bus();
        t_dividers();
        t_stop();
        give_verdict();
    end
endmodule

/* tb/pgf_port_filter_checker.sv */
// checker: bus and pin timing relations of the port glitch filter
`timescale 1ns/1ps
module pgf_port_filter_checker #(
    parameter int PB_W = 8, // port b pins
    parameter int PC_W = 4  // port c pins
) (
    // clock and reset
    input wire logic                        pclk,
    input wire logic                        presetn,
    // apb slave
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [pgf_pkg::ADDR_W-1:0]  paddr,
    input wire logic [31:0]                 pwdata,
    input wire logic [3:0]                  pstrb,
    input wire logic [31:0]                 prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    // watched pins
    input wire logic [PB_W-1:0]             port_b,
    input wire logic [PB_W-1:0]             port_b_filtered,
    input wire logic [PC_W-1:0]             port_c_filtered,
    input wire logic                        reset_irq_pin,
    input wire logic                        reset_irq_filtered
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       acc;    // access phase
    logic       rd;     // read access phase
    logic       mapped; // one of the four registers
    logic [3:0] gate_q; // shadow of the port c gate bits
    assign acc = psel && penable;
    assign rd = acc && !pwrite;
    assign mapped = paddr inside {pgf_pkg::ADDR_PORT_C_INPUT_GATE, pgf_pkg::ADDR_PORT_GROUP_FILTER,
                                  pgf_pkg::ADDR_WAKEUP_RESET_FILTER, pgf_pkg::ADDR_FILTER_CLOCK_DIV};
    // shadow follows only writes with the low byte lane strobed, as the slave does
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_q <= 4'h0;
        end else if (acc && pwrite && pstrb[0] && paddr == pgf_pkg::ADDR_PORT_C_INPUT_GATE) begin
            gate_q <= pwdata[3:0];
        end
    end
    a_ready_access: assert property (pready == acc) else $error("pready off access phase");
    a_err_unmapped: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_upper_zero: assert property (rd |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_gate_read: assert property (rd && paddr == pgf_pkg::ADDR_PORT_C_INPUT_GATE
        |-> prdata[7:0] == {4'h0, gate_q}) else $error("gate readback wrong");
    a_group_reserved: assert property (rd && paddr == pgf_pkg::ADDR_PORT_GROUP_FILTER
        |-> prdata[7:6] == 2'h0) else $error("group filter reserved bits set");
    a_wake_reserved: assert property (rd && paddr == pgf_pkg::ADDR_WAKEUP_RESET_FILTER
        |-> prdata[7:4] == 4'h0) else $error("wakeup filter reserved bits set");
    a_gate_blocks: assert property (!gate_q[0] [*3] |-> !port_c_filtered[0])
        else $error("gated pin reached logic");
    a_rise_held: assert property ($rose(reset_irq_filtered) |-> $past(reset_irq_pin, 3))
        else $error("reset pin output rose without input");
    a_fall_held: assert property ($fell(port_b_filtered[0]) |-> !$past(port_b[0], 3))
        else $error("port b output fell without input");
endmodule
bind pgf_port_filter pgf_port_filter_checker #(.PB_W(PB_W), .PC_W(PC_W)) i_pgf_port_filter_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_b(port_b), .port_b_filtered(port_b_filtered),
    .port_c_filtered(port_c_filtered), .reset_irq_pin(reset_irq_pin),
    .reset_irq_filtered(reset_irq_filtered));
